// file: hspa_pkg.sv
package hspa_pkg;

   // -----------------------------------------------------------------
   // Register map of the device (word index on the six-bit address).
   // -----------------------------------------------------------------
   localparam logic [5:0]  HSPA_CMD_IDX   = 6'h00;
   localparam logic [5:0]  HSPA_DCR_IDX   = 6'h01;
   localparam logic [5:0]  HSPA_RCR_IDX   = 6'h02;
   localparam logic [5:0]  HSPA_TCR_IDX   = 6'h03;
   localparam logic [5:0]  HSPA_IMR_IDX   = 6'h04;
   localparam logic [5:0]  HSPA_ISR_IDX   = 6'h05;
   localparam logic [5:0]  HSPA_END_OF_BUFFER_COUNT_IDX  = 6'h06;
   localparam logic [5:0]  HSPA_CAME_IDX  = 6'h07;
   localparam logic [5:0]  HSPA_DATA_CONFIG_REG_TWO_IDX  = 6'h08;

   // -----------------------------------------------------------------
   // Reset values and fields.
   // -----------------------------------------------------------------
   localparam logic [15:0] HSPA_CMD_RST     = 16'h0094;
   localparam logic [15:0] HSPA_CMD_SWR_A   = 16'h0094;
   localparam logic [15:0] HSPA_CMD_SWR_B   = 16'h00a4;
   localparam int          HSPA_CMD_RST_BIT = 7;
   localparam logic [15:0] HSPA_TCR_RST     = 16'h0101;
   localparam logic [15:0] HSPA_END_OF_BUFFER_COUNT_RST    = 16'h02f8;
   localparam logic [15:0] HSPA_DCR_CLR     = 16'h5fff;
   localparam logic [15:0] HSPA_DATA_CONFIG_REG_TWO_CLR    = 16'hffe0;
   localparam logic [15:0] HSPA_RCR_CLR     = 16'hf9ff;
   localparam int          HSPA_TCR_PTX_BIT = 0;
   localparam int          HSPA_TCR_CRS_BIT = 8;

   // -----------------------------------------------------------------
   // Timing in bus clocks (HSPA_RDY_HALF in half clocks).
   // -----------------------------------------------------------------
   localparam int          HSPA_WR_CAPTURE  = 2;
   localparam int          HSPA_RDY_HALF    = 5;
   localparam int          HSPA_MASTER_MAX  = 4;
   localparam int          HSPA_CS_TO_HOST_MEMORY_REQUEST_N  = 2;

   // -----------------------------------------------------------------
   // APB command registers of the host end (byte addresses).
   // -----------------------------------------------------------------
   localparam logic [7:0]  HSPA_H_CTRL   = 8'h00;
   localparam logic [7:0]  HSPA_H_WDATA  = 8'h04;
   localparam logic [7:0]  HSPA_H_STATUS = 8'h08;
   localparam logic [7:0]  HSPA_H_RDATA  = 8'h0c;
   localparam logic [7:0]  HSPA_H_MEM    = 8'h10;

endpackage

// file: hspa_if.sv
interface hspa_if;
   import hspa_pkg::*;
   logic        cs_n;
   logic        slave_address_strobe_n;
   logic        slave_write_not_read;
   logic [5:0]  register_address_lines;
   logic        host_memory_request_n;
   logic        slave_mem_acknowledge_n;
   logic        slave_ready_out_n;
   logic [15:0] host_data;
   logic [15:0] dev_data;
   logic        dev_data_oe_n;

   modport dev (
      input  cs_n,
      input  slave_address_strobe_n,
      input  slave_write_not_read,
      input  register_address_lines,
      input  host_memory_request_n,
      input  host_data,
      output slave_mem_acknowledge_n,
      output slave_ready_out_n,
      output dev_data,
      output dev_data_oe_n
   );

   modport host (
      output cs_n,
      output slave_address_strobe_n,
      output slave_write_not_read,
      output register_address_lines,
      output host_memory_request_n,
      output host_data,
      input  slave_mem_acknowledge_n,
      input  slave_ready_out_n,
      input  dev_data,
      input  dev_data_oe_n
   );
endinterface

// file: hspa_device.sv
module hspa_device
   import hspa_pkg::*;
#(
   parameter int MASTER_CYC = 2
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic master_busy,
   input  wire logic [15:0] timer_cmd_bits,
   hspa_if.dev       bus,
   output logic      dma_enable,
   output logic      irq_enable,
   output logic      loopback_on
);

   typedef enum logic [2:0] {
      HSPA_IDLE, HSPA_WAIT_MASTER, HSPA_ACK, HSPA_DONE, HSPA_MEM
   } hspa_dstate_t;

   typedef struct packed {
      hspa_dstate_t state;
      logic [2:0]   cnt;
      logic [5:0]   addr;
      logic         wnr;
      logic         ack_n;
      logic         clr_pend;
      logic         oe_n;
      logic [15:0]  rdata;
      logic         sas_q;
      logic [15:0]  cmd, data_config_reg, data_config_reg_two, receive_control_reg, transmit_control_reg, interrupt_mask_reg, interrupt_status_reg, end_of_buffer_count, came;
      logic         host_memory_request_n_r1, host_memory_request_n_r2;
      logic         swr_a;
   } hspa_dev_t;

   hspa_dev_t r;
   hspa_dev_t n;

   // ------------------------------------------------------------
   // Falling edge samplers for the asynchronous strobes.
   // ------------------------------------------------------------
   logic cs_f1, cs_f2, sas_f1, sas_f2, host_memory_request_n_f1, host_memory_request_n_f2;
   logic rdy_half_n;
   logic [5:0] lat_addr;
   logic       lat_wnr;

   always_ff @(negedge pclk or negedge presetn) begin
      if (!presetn) begin
         cs_f1   <= 1'b1;
         cs_f2   <= 1'b1;
         sas_f1  <= 1'b1;
         sas_f2  <= 1'b1;
         host_memory_request_n_f1 <= 1'b1;
         host_memory_request_n_f2 <= 1'b1;
         rdy_half_n <= 1'b1;
      end else begin
         cs_f1   <= bus.cs_n;
         cs_f2   <= cs_f1;
         sas_f1  <= bus.slave_address_strobe_n;
         sas_f2  <= sas_f1;
         host_memory_request_n_f1 <= bus.host_memory_request_n;
         host_memory_request_n_f2 <= host_memory_request_n_f1;
         if (r.state != HSPA_ACK) begin
            rdy_half_n <= 1'b1;
         end else if (r.cnt == 3'((HSPA_RDY_HALF + 1) / 2)) begin
            rdy_half_n <= 1'b0;
         end
      end
   end

   // Address and direction latched on the strobe rising edge.
   always_ff @(posedge bus.slave_address_strobe_n or negedge presetn) begin
      if (!presetn) begin
         lat_addr <= 6'h00;
         lat_wnr  <= 1'b0;
      end else begin
         lat_addr <= bus.register_address_lines;
         lat_wnr  <= bus.slave_write_not_read;
      end
   end

   function automatic logic [15:0] rd_mux(input hspa_dev_t s, input logic [5:0] a);
      logic [15:0] v;
      v = 16'h0000;
      if (a == HSPA_CMD_IDX) v = s.cmd;
      else if (a == HSPA_DCR_IDX) v = s.data_config_reg;
      else if (a == HSPA_RCR_IDX) v = s.receive_control_reg;
      else if (a == HSPA_TCR_IDX) v = s.transmit_control_reg;
      else if (a == HSPA_IMR_IDX) v = s.interrupt_mask_reg;
      else if (a == HSPA_ISR_IDX) v = s.interrupt_status_reg;
      else if (a == HSPA_END_OF_BUFFER_COUNT_IDX) v = s.end_of_buffer_count;
      else if (a == HSPA_CAME_IDX) v = s.came;
      else if (a == HSPA_DATA_CONFIG_REG_TWO_IDX) v = s.data_config_reg_two;
      return v;
   endfunction

   // ------------------------------------------------------------
   // Next state.
   // ------------------------------------------------------------
   logic release_cyc;
   logic [15:0] wd;

   always_comb begin
      n = r;
      n.sas_q   = sas_f2;
      n.host_memory_request_n_r1 = host_memory_request_n_f2;
      n.host_memory_request_n_r2 = r.host_memory_request_n_r1;
      n.clr_pend = 1'b0;
      if (r.clr_pend) begin
         n.data_config_reg  = r.data_config_reg & HSPA_DCR_CLR;
         n.data_config_reg_two = r.data_config_reg_two & HSPA_DATA_CONFIG_REG_TWO_CLR;
         n.receive_control_reg  = r.receive_control_reg & HSPA_RCR_CLR;
      end
      release_cyc = !bus.slave_address_strobe_n || bus.cs_n;
      wd = bus.host_data;
      case (r.state)
         HSPA_IDLE: begin
            n.ack_n = 1'b1;
            n.oe_n  = 1'b1;
            if (!cs_f2 && sas_f2 && !r.sas_q) begin
               n.addr = lat_addr;
               n.wnr  = lat_wnr;
               n.cnt  = 3'h0;
               n.state = master_busy ? HSPA_WAIT_MASTER : HSPA_ACK;
            end else if (!r.host_memory_request_n_r2 && cs_f2) begin
               n.cnt = 3'h0;
               n.state = master_busy ? HSPA_WAIT_MASTER : HSPA_MEM;
            end
         end
         HSPA_WAIT_MASTER: begin
            n.cnt = r.cnt + 3'h1;
            if (!master_busy || r.cnt == 3'(MASTER_CYC)) begin
               n.cnt = 3'h0;
               n.state = r.host_memory_request_n_r2 ? HSPA_ACK : HSPA_MEM;
            end
         end
         HSPA_ACK: begin
            n.ack_n = 1'b0;
            if (r.cnt == 3'h0 && !r.wnr) begin
               n.rdata = rd_mux(r, r.addr);
               n.oe_n  = 1'b0;
            end
            n.cnt = r.cnt + 3'h1;
            if (r.cnt == 3'(HSPA_WR_CAPTURE) && r.wnr) begin
               if (r.addr == HSPA_CMD_IDX) begin
                  n.cmd = wd;
                  if (wd[HSPA_CMD_RST_BIT]) begin
                     n.cmd = r.swr_a ? HSPA_CMD_SWR_A : HSPA_CMD_SWR_B;
                  end
               end
               else if (r.addr == HSPA_DCR_IDX) n.data_config_reg = wd;
               else if (r.addr == HSPA_RCR_IDX) n.receive_control_reg = wd;
               else if (r.addr == HSPA_TCR_IDX) n.transmit_control_reg = wd;
               else if (r.addr == HSPA_IMR_IDX) n.interrupt_mask_reg = wd;
               else if (r.addr == HSPA_ISR_IDX) n.interrupt_status_reg = r.interrupt_status_reg & ~wd;
               else if (r.addr == HSPA_END_OF_BUFFER_COUNT_IDX) n.end_of_buffer_count = wd;
               else if (r.addr == HSPA_CAME_IDX) n.came = wd;
               else if (r.addr == HSPA_DATA_CONFIG_REG_TWO_IDX) n.data_config_reg_two = wd;
            end
            if (r.cnt >= 3'((HSPA_RDY_HALF + 1) / 2)) n.cnt = r.cnt;
            if (release_cyc && r.cnt != 3'h0) begin
               n.ack_n = 1'b1;
               n.oe_n  = 1'b1;
               n.state = HSPA_DONE;
            end
         end
         HSPA_DONE: begin
            n.ack_n = 1'b1;
            n.oe_n  = 1'b1;
            n.state = HSPA_IDLE;
         end
         HSPA_MEM: begin
            n.ack_n = 1'b0;
            if (r.host_memory_request_n_r2) begin
               n.ack_n = 1'b1;
               n.state = HSPA_IDLE;
            end
         end
         default: n.state = HSPA_IDLE;
      endcase
      n.swr_a = timer_cmd_bits[0];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r.state    <= HSPA_IDLE;
         r.cnt      <= 3'h0;
         r.addr     <= 6'h00;
         r.wnr      <= 1'b0;
         r.ack_n    <= 1'b1;
         r.oe_n     <= 1'b1;
         r.rdata    <= 16'h0000;
         r.sas_q    <= 1'b1;
         r.host_memory_request_n_r1  <= 1'b1;
         r.host_memory_request_n_r2  <= 1'b1;
         r.swr_a    <= 1'b0;
         r.clr_pend <= 1'b1;
         r.cmd      <= HSPA_CMD_RST;
         r.transmit_control_reg      <= HSPA_TCR_RST;
         r.end_of_buffer_count     <= HSPA_END_OF_BUFFER_COUNT_RST;
         r.interrupt_mask_reg      <= 16'h0000;
         r.interrupt_status_reg      <= 16'h0000;
         r.came     <= 16'h0000;
      end else begin
         r <= n;
      end
   end

   // ------------------------------------------------------------
   // Outputs.
   // ------------------------------------------------------------
   assign bus.slave_mem_acknowledge_n = r.ack_n;
   assign bus.slave_ready_out_n       = rdy_half_n;
   assign bus.dev_data                = r.rdata;
   assign bus.dev_data_oe_n           = r.oe_n;
   assign dma_enable  = !r.cmd[HSPA_CMD_RST_BIT];
   assign irq_enable  = |r.interrupt_mask_reg && !r.cmd[HSPA_CMD_RST_BIT];
   assign loopback_on = |r.receive_control_reg[10:9];

endmodule

// file: hspa_host.sv
module hspa_host
   import hspa_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   hspa_if.host             bus
);

   typedef enum logic [2:0] {
      HSPH_IDLE, HSPH_STROBE, HSPH_WAIT, HSPH_GAP, HSPH_MEMREQ, HSPH_MEMHOLD
   } hspa_hstate_t;

   typedef struct packed {
      hspa_hstate_t state;
      logic         cs_n, sas_n, wnr, host_memory_request_n_n;
      logic [5:0]   addr;
      logic [15:0]  wdata, rdata;
      logic         busy, granted;
      logic [1:0]   gap;
      logic         ack1, ack2, rdy1, rdy2;
      logic [31:0]  prdata;
      logic         pready;
   } hspa_host_st_t;

   hspa_host_st_t r;
   hspa_host_st_t n;
   logic acc;

   always_comb begin
      n = r;
      n.ack1 = bus.slave_mem_acknowledge_n;
      n.ack2 = r.ack1;
      n.rdy1 = bus.slave_ready_out_n;
      n.rdy2 = r.rdy1;
      n.pready = 1'b0;
      acc = psel && penable && !r.pready;
      if (acc) begin
         n.pready = 1'b1;
         n.prdata = 32'h0000_0000;
         if (pwrite) begin
            if (paddr == HSPA_H_CTRL && r.state == HSPH_IDLE && !r.busy) begin
               n.addr = pwdata[5:0];
               n.wnr  = pwdata[8];
               n.busy = 1'b1;
               n.sas_n = 1'b0;
               n.state = HSPH_STROBE;
            end else if (paddr == HSPA_H_WDATA) begin
               n.wdata = pwdata[15:0];
            end else if (paddr == HSPA_H_MEM && r.state == HSPH_IDLE) begin
               n.state = pwdata[0] ? HSPH_MEMREQ : HSPH_IDLE;
            end else if (paddr == HSPA_H_MEM && r.state == HSPH_MEMHOLD) begin
               if (!pwdata[0]) begin
                  n.host_memory_request_n_n = 1'b1;
                  n.granted = 1'b0;
                  n.state = HSPH_IDLE;
               end
            end
         end else begin
            if (paddr == HSPA_H_STATUS) n.prdata = {30'h0, r.granted, r.busy};
            else if (paddr == HSPA_H_RDATA) n.prdata = {16'h0000, r.rdata};
         end
      end
      case (r.state)
         HSPH_STROBE: begin
            n.cs_n  = 1'b0;
            n.sas_n = 1'b1;
            n.state = HSPH_WAIT;
         end
         HSPH_WAIT: begin
            if (!r.rdy2) begin
               if (!r.wnr) n.rdata = bus.dev_data;
               n.cs_n  = 1'b1;
               n.busy  = 1'b0;
               n.gap   = 2'(HSPA_CS_TO_HOST_MEMORY_REQUEST_N);
               n.state = HSPH_GAP;
            end
         end
         HSPH_GAP: begin
            n.gap = r.gap - 2'h1;
            if (r.gap == 2'h0) n.state = HSPH_IDLE;
         end
         HSPH_MEMREQ: begin
            n.host_memory_request_n_n = 1'b0;
            if (!r.ack2 && !r.host_memory_request_n_n) begin
               n.granted = 1'b1;
               n.state = HSPH_MEMHOLD;
            end
         end
         default: ;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r        <= '0;
         r.state  <= HSPH_IDLE;
         r.cs_n   <= 1'b1;
         r.sas_n  <= 1'b1;
         r.host_memory_request_n_n <= 1'b1;
         r.ack1   <= 1'b1;
         r.ack2   <= 1'b1;
         r.rdy1   <= 1'b1;
         r.rdy2   <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign prdata  = r.prdata;
   assign pready  = r.pready;
   assign pslverr = 1'b0;
   assign bus.cs_n                   = r.cs_n;
   assign bus.slave_address_strobe_n = r.sas_n;
   assign bus.slave_write_not_read   = r.wnr;
   assign bus.register_address_lines = r.addr;
   assign bus.host_memory_request_n  = r.host_memory_request_n_n;
   assign bus.host_data              = r.wdata;

endmodule

// file: hspa_assertions.sv
module hspa_assertions
   import hspa_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        cs_n,
   input wire logic        slave_address_strobe_n,
   input wire logic        slave_write_not_read,
   input wire logic [5:0]  register_address_lines,
   input wire logic        host_memory_request_n,
   input wire logic        slave_mem_acknowledge_n,
   input wire logic        slave_ready_out_n,
   input wire logic [15:0] host_data,
   input wire logic [15:0] dev_data,
   input wire logic        dev_data_oe_n
);
   // ---------------------------------------------------------------
   // Link protocol checks.
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_ack_start;
      ($rose(slave_address_strobe_n) && !cs_n) |-> ##[1:12] !slave_mem_acknowledge_n;
   endproperty
   a_ack_start: assert property (p_ack_start) else $error("no acknowledge after strobe");

   property p_ack_cause;
      $fell(slave_mem_acknowledge_n) |-> (!cs_n && slave_address_strobe_n)
         || (cs_n && $past(!host_memory_request_n));
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("acknowledge without cause");

   property p_rdy_after_ack;
      ($fell(slave_mem_acknowledge_n) && !cs_n)
         |-> slave_ready_out_n [*2] ##1 !slave_ready_out_n;
   endproperty
   a_rdy_after_ack: assert property (p_rdy_after_ack) else $error("ready timing wrong");

   property p_read_data;
      $fell(dev_data_oe_n) |-> $fell(slave_mem_acknowledge_n) && !cs_n;
   endproperty
   a_read_data: assert property (p_read_data) else $error("read data not with acknowledge");

   property p_oe_only_ack;
      !dev_data_oe_n |-> !slave_mem_acknowledge_n && (!cs_n || $past(!cs_n));
   endproperty
   a_oe_only_ack: assert property (p_oe_only_ack) else $error("data driven outside cycle");

   property p_req_stable;
      (!cs_n && $past(!cs_n))
         |-> $stable(register_address_lines) && $stable(slave_write_not_read)
            && $stable(host_data);
   endproperty
   a_req_stable: assert property (p_req_stable) else $error("request changed in cycle");

   property p_rdata_stable;
      (!dev_data_oe_n && $past(!dev_data_oe_n)) |-> $stable(dev_data);
   endproperty
   a_rdata_stable: assert property (p_rdata_stable) else $error("read data moved");

   property p_release;
      ($fell(slave_address_strobe_n) || $rose(cs_n))
         |-> ##[0:2] (slave_mem_acknowledge_n && slave_ready_out_n && dev_data_oe_n);
   endproperty
   a_release: assert property (p_release) else $error("cycle not released");

   property p_mem_grant;
      ($fell(host_memory_request_n) && cs_n) |-> ##[1:12] !slave_mem_acknowledge_n;
   endproperty
   a_mem_grant: assert property (p_mem_grant) else $error("memory grant late");

   property p_mem_hold;
      (cs_n && !host_memory_request_n && !slave_mem_acknowledge_n)
         |=> (!slave_mem_acknowledge_n || host_memory_request_n);
   endproperty
   a_mem_hold: assert property (p_mem_hold) else $error("memory grant dropped early");

   property p_mem_drop;
      ($rose(host_memory_request_n) && cs_n && !slave_mem_acknowledge_n)
         |-> ##[1:4] slave_mem_acknowledge_n;
   endproperty
   a_mem_drop: assert property (p_mem_drop) else $error("memory grant not removed");

   c_read: cover property ($fell(dev_data_oe_n));
   c_write: cover property ($fell(slave_mem_acknowledge_n) && !cs_n && slave_write_not_read);
   c_mem: cover property ($fell(slave_mem_acknowledge_n) && cs_n);
endmodule

// file: tb.sv
module tb
   import hspa_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;

   logic        pclk;
   logic        presetn;
   logic [7:0]  paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        master_busy;
   logic [15:0] timer_cmd_bits;
   logic        dma_enable;
   logic        irq_enable;
   logic        loopback_on;
   logic [15:0] v;
   int          bad_count;
   int          checks_done;
   logic [5:0]  row_idx [9] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08};
   logic [15:0] row_exp [9] = '{16'h0094, 16'h0000, 16'h0000, 16'h0101, 16'h0000,
                                16'h0000, 16'h02f8, 16'h0000, 16'h0000};

   hspa_if bus();
   hspa_host i_hspa_host (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bus(bus));
   hspa_device #(.MASTER_CYC(2)) i_hspa_device (.pclk(pclk), .presetn(presetn),
      .master_busy(master_busy), .timer_cmd_bits(timer_cmd_bits), .bus(bus),
      .dma_enable(dma_enable), .irq_enable(irq_enable), .loopback_on(loopback_on));
   hspa_assertions i_hspa_assertions (.pclk(pclk), .presetn(presetn), .cs_n(bus.cs_n),
      .slave_address_strobe_n(bus.slave_address_strobe_n),
      .slave_write_not_read(bus.slave_write_not_read),
      .register_address_lines(bus.register_address_lines),
      .host_memory_request_n(bus.host_memory_request_n),
      .slave_mem_acknowledge_n(bus.slave_mem_acknowledge_n),
      .slave_ready_out_n(bus.slave_ready_out_n), .host_data(bus.host_data),
      .dev_data(bus.dev_data), .dev_data_oe_n(bus.dev_data_oe_n));

   // ---------------------------------------------------------------
   // Checking and closing tasks.
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic hang();
      chk(16'h0000, 16'h0001);
      end_sim();
   endtask

   // ---------------------------------------------------------------
   // Bus tasks.
   // ---------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) hang();
      r = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic reg_cmd(input logic w, input logic [5:0] idx, input logic [15:0] d,
                          output logic [15:0] r);
      logic [31:0] t;
      int          n;
      if (w) apb(1'b1, HSPA_H_WDATA, {16'h0000, d}, t);
      apb(1'b1, HSPA_H_CTRL, {23'h000000, w, 2'b00, idx}, t);
      n = 0;
      do begin
         apb(1'b0, HSPA_H_STATUS, 32'h00000000, t);
         n++;
      end while (t[0] !== 1'b0 && n < 40);
      if (n >= 40) hang();
      apb(1'b0, HSPA_H_RDATA, 32'h00000000, t);
      r = t[15:0];
   endtask

   task automatic wait_ack(input logic lvl);
      int n;
      n = 0;
      while (bus.slave_mem_acknowledge_n !== lvl && n < 40) begin
         @(negedge pclk);
         n++;
      end
      if (n >= 40) hang();
      chk({15'h0000, bus.slave_mem_acknowledge_n}, {15'h0000, lvl});
   endtask

   task automatic hw_reset(input int cyc);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (cyc) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // ---------------------------------------------------------------
   // Main sequence.
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] t;
      presetn = 1'b0; paddr = 8'h00; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      pwdata = 32'h00000000; master_busy = 1'b0; timer_cmd_bits = 16'h0001;
      bad_count = 0; checks_done = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      reg_cmd(1'b1, HSPA_DCR_IDX, 16'h0000, v);
      reg_cmd(1'b1, HSPA_DATA_CONFIG_REG_TWO_IDX, 16'h0000, v);
      reg_cmd(1'b1, HSPA_RCR_IDX, 16'h0000, v);
      for (int i = 0; i < 9; i++) begin
         reg_cmd(1'b0, row_idx[i], 16'h0000, v);
         chk(v, row_exp[i]);
      end
      chk({13'h0000, dma_enable, irq_enable, loopback_on}, 16'h0000);
      $display("test reset values done");
      master_busy <= 1'b1;
      reg_cmd(1'b1, HSPA_IMR_IDX, 16'hffff, v);
      reg_cmd(1'b0, HSPA_IMR_IDX, 16'h0000, v);
      chk(v, 16'hffff);
      master_busy <= 1'b0;
      reg_cmd(1'b1, HSPA_CMD_IDX, 16'h0000, v);
      chk({14'h0000, dma_enable, irq_enable}, 16'h0003);
      reg_cmd(1'b1, HSPA_TCR_IDX, 16'h0000, v);
      $display("test write while mastering done");
      for (int b = 0; b < 2; b++) begin
         timer_cmd_bits <= {15'h0000, b[0]};
         reg_cmd(1'b1, HSPA_CMD_IDX, 16'h0080, v);
         reg_cmd(1'b0, HSPA_CMD_IDX, 16'h0000, v);
         chk(v, b[0] ? 16'h0094 : 16'h00a4);
         reg_cmd(1'b0, HSPA_TCR_IDX, 16'h0000, v);
         chk(v, 16'h0000);
         reg_cmd(1'b0, HSPA_IMR_IDX, 16'h0000, v);
         chk(v, 16'hffff);
         chk({15'h0000, dma_enable}, 16'h0000);
      end
      $display("test software reset done");
      reg_cmd(1'b1, HSPA_DCR_IDX, 16'hffff, v);
      reg_cmd(1'b1, HSPA_DATA_CONFIG_REG_TWO_IDX, 16'hffff, v);
      reg_cmd(1'b1, HSPA_RCR_IDX, 16'hffff, v);
      hw_reset(10);
      reg_cmd(1'b0, HSPA_DCR_IDX, 16'h0000, v);
      chk(v, 16'h5fff);
      reg_cmd(1'b0, HSPA_DATA_CONFIG_REG_TWO_IDX, 16'h0000, v);
      chk(v, 16'hffe0);
      reg_cmd(1'b0, HSPA_RCR_IDX, 16'h0000, v);
      chk(v, 16'hf9ff);
      reg_cmd(1'b0, HSPA_IMR_IDX, 16'h0000, v);
      chk(v, 16'h0000);
      chk({15'h0000, loopback_on}, 16'h0000);
      $display("test hardware reset done");
      for (int b = 0; b < 2; b++) begin
         master_busy <= b[0];
         apb(1'b1, HSPA_H_MEM, 32'h00000001, t);
         wait_ack(1'b0);
         repeat (6) @(posedge pclk);
         chk({15'h0000, bus.slave_mem_acknowledge_n}, 16'h0000);
         apb(1'b1, HSPA_H_MEM, 32'h00000000, t);
         wait_ack(1'b1);
         reg_cmd(1'b0, HSPA_END_OF_BUFFER_COUNT_IDX, 16'h0000, v);
         chk(v, 16'h02f8);
      end
      master_busy <= 1'b0;
      $display("test memory arbiter done");
      end_sim();
   end
endmodule
